// >>> ctrl_ea_pkg.sv
package ctrl_ea_pkg;

  // Control opcodes
  localparam logic [7:0] OP_COPY_ACC_TO_INDEX  = 8'h97;
  localparam logic [7:0] OP_COPY_INDEX_TO_ACC  = 8'h9f;
  localparam logic [7:0] OP_CARRY_SET          = 8'h99;
  localparam logic [7:0] OP_CARRY_CLEAR        = 8'h98;
  localparam logic [7:0] OP_IRQ_MASK_SET       = 8'h9b;
  localparam logic [7:0] OP_IRQ_MASK_CLEAR     = 8'h9a;
  localparam logic [7:0] OP_SOFT_INTERRUPT     = 8'h83;
  localparam logic [7:0] OP_SUB_RETURN         = 8'h81;
  localparam logic [7:0] OP_INTERRUPT_RETURN   = 8'h80;
  localparam logic [7:0] OP_STACK_POINTER_RST  = 8'h9c;
  localparam logic [7:0] OP_NO_OPERATION       = 8'h9d;
  localparam logic [7:0] OP_STOP_ENTRY         = 8'h8e;
  localparam logic [7:0] OP_WAIT_ENTRY         = 8'h8f;

  // Bit-op opcode groups (high nibble)
  localparam logic [3:0] BIT_BRANCH_NIBBLE = 4'h0;
  localparam logic [3:0] BIT_SETCLR_NIBBLE = 4'h1;

  // Cycle counts in bus clock cycles
  localparam logic [3:0] CYC_SHORT_CTRL  = 4'h2;
  localparam logic [3:0] CYC_SOFT_INT    = 4'ha;
  localparam logic [3:0] CYC_SUB_RETURN  = 4'h6;
  localparam logic [3:0] CYC_INT_RETURN  = 4'h9;

  // Program counter steps
  localparam logic [15:0] PC_STEP_ONE   = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO   = 16'h0002;
  localparam logic [15:0] PC_STEP_THREE = 16'h0003;

  // Reset values
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [7:0]  SP_RESET     = 8'hff;
  localparam logic [7:0]  REG8_RESET   = 8'h00;
  // Arbitrary nonzero value, so a copy into index makes indexed sums carry
  localparam logic [7:0]  ACC_RESET    = 8'hc7;
  localparam logic        IMASK_RESET  = 1'b1;

  typedef enum logic [9:0] {
    MODE_INHERENT   = 10'h001,
    MODE_IMMEDIATE  = 10'h002,
    MODE_DIRECT     = 10'h004,
    MODE_EXTENDED   = 10'h008,
    MODE_INDEXED_0  = 10'h010,
    MODE_INDEXED_8  = 10'h020,
    MODE_INDEXED_16 = 10'h040,
    MODE_RELATIVE   = 10'h080,
    MODE_BIT_SETCLR = 10'h100,
    MODE_BIT_BRANCH = 10'h200
  } addr_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } ctrl_state_t;

  // Instruction bytes as fetched at pc, pc+1, pc+2
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } instr_bytes_t;

  // Address-generation result
  typedef struct packed {
    logic [15:0] effective_address;
    logic [15:0] next_pc;
    logic [2:0]  bit_number;
  } ea_result_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] index;
    logic [7:0] sp;
    logic       carry;
    logic       irq_mask;
  } core_regs_t;

endpackage

// >>> ctrl_ea_gen.sv
`timescale 1ns/10ps
// Operation
// - Accumulator/index copies and carry set/clear run for two cycles each.
// - Opcode 9B sets the interrupt mask and 9A clears it, each in two cycles.
// - Soft interrupt takes 10 cycles, subroutine return 6, interrupt return 9.
// - Stack pointer reset, no-operation, stop and wait entry take two cycles.
// - Inherent instructions take no operand bytes and advance the program counter by one.
// - Immediate mode addresses pc+1 and advances the program counter by two.
// - Direct mode uses a zero high byte and the byte after the opcode as low byte.
// - Extended mode takes high then low byte after the opcode and advances pc by three.
// - Indexed without offset uses the index register as low byte, zero high, one byte.
// - Eight-bit offset indexing adds offset to index with the carry as high byte.
// - Sixteen-bit offset indexing adds index to the low byte and carries into the high.
// - A relative branch loads pc+2+offset when taken, else pc+2.
// - Bit set/clear addresses the direct byte with bit number from opcode bits 3:1.
// - Bit test-and-branch tests the addressed bit and loads pc+3+offset when taken.
// - Bit test-and-branch copies the tested bit into carry.
// - Bit set is 10+2n, clear 11+2n, branch-if-set 2n, branch-if-clear 01+2n.
module ctrl_ea_gen
  import ctrl_ea_pkg::*;
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Instruction issue
  input  wire logic         instr_valid,
  input  wire instr_bytes_t instr,
  input  wire addr_mode_t   mode,
  input  wire logic         branch_cond,
  input  wire logic [7:0]   operand_data,
  output logic              instr_ready,
  // Address and state outputs
  output ea_result_t        ea_out,
  output core_regs_t        regs_out,
  output logic [15:0]       pc_out,
  output logic              instr_done,
  output logic              stop_req,
  output logic              wait_req,
  output logic              is_bit_set,
  output logic              is_bit_clear
);

  ctrl_state_t  state_q, state_d;
  logic [3:0]   cnt_q, cnt_d;
  logic [15:0]  pc_q, pc_d;
  core_regs_t   regs_q, regs_d;
  ea_result_t   ea_q, ea_d;
  logic         done_q, done_d;
  logic         stop_q, stop_d;
  logic         wait_q, wait_d;
  logic         bit_set_op_q, bit_set_op_d;
  logic         bit_clear_op_q, bit_clear_op_d;

  // Sum of a 16-bit base and a sign-extended byte, wrapping
  function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [7:0] off);
    rel_target = base + {{8{off[7]}}, off};
  endfunction

  // Cycles taken by a control opcode; any other opcode also gets two cycles
  function automatic logic [3:0] ctrl_cycles(input logic [7:0] op);
    case (op)
      OP_SOFT_INTERRUPT:   ctrl_cycles = CYC_SOFT_INT;
      OP_SUB_RETURN:       ctrl_cycles = CYC_SUB_RETURN;
      OP_INTERRUPT_RETURN: ctrl_cycles = CYC_INT_RETURN;
      OP_COPY_ACC_TO_INDEX, OP_COPY_INDEX_TO_ACC, OP_CARRY_SET, OP_CARRY_CLEAR,
      OP_IRQ_MASK_SET, OP_IRQ_MASK_CLEAR, OP_STACK_POINTER_RST, OP_NO_OPERATION,
      OP_STOP_ENTRY, OP_WAIT_ENTRY:
                           ctrl_cycles = CYC_SHORT_CTRL;
      default:             ctrl_cycles = CYC_SHORT_CTRL;
    endcase
  endfunction

  assign instr_ready = (state_q == ST_IDLE);

  always_comb begin
    logic [8:0]  sum8;
    logic        bit_val;
    logic        take;
    sum8    = {1'b0, regs_q.index} + {1'b0, instr.byte1};
    bit_val = operand_data[instr.opcode[3:1]];
    take    = 1'b0;
    state_d = state_q;
    cnt_d   = cnt_q;
    pc_d    = pc_q;
    regs_d  = regs_q;
    ea_d    = ea_q;
    done_d  = 1'b0;
    stop_d  = 1'b0;
    wait_d  = 1'b0;
    bit_set_op_d  = 1'b0;
    bit_clear_op_d  = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (instr_valid) begin
          ea_d.bit_number = 3'h0;
          case (mode)
            MODE_INHERENT: begin
              // Opcode alone; no operand bytes consumed
              ea_d.effective_address = pc_q;
              ea_d.next_pc           = pc_q + PC_STEP_ONE;
              cnt_d                  = ctrl_cycles(instr.opcode) - 4'h1;
              case (instr.opcode)
                OP_COPY_ACC_TO_INDEX: regs_d.index    = regs_q.acc;
                OP_COPY_INDEX_TO_ACC: regs_d.acc      = regs_q.index;
                OP_CARRY_SET:         regs_d.carry    = 1'b1;
                OP_CARRY_CLEAR:       regs_d.carry    = 1'b0;
                OP_IRQ_MASK_SET:      regs_d.irq_mask = 1'b1;
                OP_IRQ_MASK_CLEAR:    regs_d.irq_mask = 1'b0;
                OP_STACK_POINTER_RST: regs_d.sp       = SP_RESET;
                OP_STOP_ENTRY:        stop_d          = 1'b1;
                OP_WAIT_ENTRY:        wait_d          = 1'b1;
                default:              regs_d          = regs_q;
              endcase
            end
            MODE_IMMEDIATE: begin
              ea_d.effective_address = pc_q + PC_STEP_ONE;
              ea_d.next_pc           = pc_q + PC_STEP_TWO;
              cnt_d                  = 4'h1;
            end
            MODE_DIRECT: begin
              ea_d.effective_address = {8'h00, instr.byte1};
              ea_d.next_pc           = pc_q + PC_STEP_TWO;
              cnt_d                  = 4'h1;
            end
            MODE_EXTENDED: begin
              ea_d.effective_address = {instr.byte1, instr.byte2};
              ea_d.next_pc           = pc_q + PC_STEP_THREE;
              cnt_d                  = 4'h1;
            end
            MODE_INDEXED_0: begin
              ea_d.effective_address = {8'h00, regs_q.index};
              ea_d.next_pc           = pc_q + PC_STEP_ONE;
              cnt_d                  = 4'h1;
            end
            MODE_INDEXED_8: begin
              // Carry of the byte sum becomes the high byte
              ea_d.effective_address = {7'h00, sum8};
              ea_d.next_pc           = pc_q + PC_STEP_TWO;
              cnt_d                  = 4'h1;
            end
            MODE_INDEXED_16: begin
              // Low offset byte plus index, carry into high
              ea_d.effective_address = {instr.byte1, instr.byte2} + {8'h00, regs_q.index};
              ea_d.next_pc           = pc_q + PC_STEP_THREE;
              cnt_d                  = 4'h1;
            end
            MODE_RELATIVE: begin
              take                   = branch_cond;
              ea_d.next_pc           = take ? rel_target(pc_q + PC_STEP_TWO, instr.byte1)
                                            : pc_q + PC_STEP_TWO;
              // Untaken branch points the address at the next opcode
              ea_d.effective_address = ea_d.next_pc;
              cnt_d                  = 4'h1;
            end
            MODE_BIT_SETCLR: begin
              // Even low bit is set, odd is clear
              ea_d.effective_address = {8'h00, instr.byte1};
              ea_d.bit_number        = instr.opcode[3:1];
              ea_d.next_pc           = pc_q + PC_STEP_TWO;
              bit_set_op_d = (instr.opcode[7:4] == BIT_SETCLR_NIBBLE) & ~instr.opcode[0];
              bit_clear_op_d = (instr.opcode[7:4] == BIT_SETCLR_NIBBLE) & instr.opcode[0];
              cnt_d                  = 4'h1;
            end
            MODE_BIT_BRANCH: begin
              // Even opcode branches on set, odd on clear
              take                   = instr.opcode[0] ? ~bit_val : bit_val;
              regs_d.carry           = bit_val;
              ea_d.effective_address = {8'h00, instr.byte1};
              ea_d.bit_number        = instr.opcode[3:1];
              ea_d.next_pc           = take ? rel_target(pc_q + PC_STEP_THREE, instr.byte2)
                                            : pc_q + PC_STEP_THREE;
              cnt_d                  = 4'h1;
            end
            default: begin
              ea_d.effective_address = pc_q;
              ea_d.next_pc           = pc_q + PC_STEP_ONE;
              cnt_d                  = 4'h1;
            end
          endcase
          pc_d    = ea_d.next_pc;
          state_d = ST_BUSY;
        end
      end
      ST_BUSY: begin
        // Count down remaining bus cycles
        if (cnt_q <= 4'h1) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
          cnt_d   = 4'h0;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      pc_q    <= PC_RESET;
      regs_q  <= '{acc: ACC_RESET, index: REG8_RESET, sp: SP_RESET,
                   carry: 1'b0, irq_mask: IMASK_RESET};
      ea_q    <= '0;
      done_q  <= 1'b0;
      stop_q  <= 1'b0;
      wait_q  <= 1'b0;
      bit_set_op_q  <= 1'b0;
      bit_clear_op_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pc_q    <= pc_d;
      regs_q  <= regs_d;
      ea_q    <= ea_d;
      done_q  <= done_d;
      stop_q  <= stop_d;
      wait_q  <= wait_d;
      bit_set_op_q  <= bit_set_op_d;
      bit_clear_op_q  <= bit_clear_op_d;
    end
  end

  assign ea_out       = ea_q;
  assign regs_out     = regs_q;
  assign pc_out       = pc_q;
  assign instr_done   = done_q;
  assign stop_req     = stop_q;
  assign wait_req     = wait_q;
  assign is_bit_set   = bit_set_op_q;
  assign is_bit_clear = bit_clear_op_q;

  // Checks
  logic issue;
  assign issue = instr_valid && instr_ready;

  chk_short_ctrl_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_INHERENT && instr.opcode == OP_CARRY_SET
    |=> !instr_ready ##1 instr_done && instr_ready)
    else $error("two-cycle control op wrong length");

  chk_mask_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_INHERENT && instr.opcode == OP_IRQ_MASK_SET |=> regs_out.irq_mask)
    else $error("mask not set");

  chk_soft_int_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_INHERENT && instr.opcode == OP_SOFT_INTERRUPT
    |=> (!instr_done) [*8] ##1 !instr_done ##1 instr_done)
    else $error("soft interrupt not ten cycles");

  chk_stop_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_INHERENT && instr.opcode == OP_STOP_ENTRY |=> stop_req ##1 instr_done)
    else $error("stop entry wrong");

  chk_inherent_pc: assert property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_INHERENT |=> pc_out == $past(pc_out) + PC_STEP_ONE)
    else $error("inherent pc step wrong");

  chk_immediate_ea: assert property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_IMMEDIATE
    |=> ea_out.effective_address == $past(pc_out) + PC_STEP_ONE
        && pc_out == $past(pc_out) + PC_STEP_TWO)
    else $error("immediate address wrong");

  chk_direct_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
    issue && (mode == MODE_DIRECT || mode == MODE_INDEXED_0)
    |=> ea_out.effective_address[15:8] == 8'h00)
    else $error("direct high byte nonzero");

  chk_extended_pc: assert property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_EXTENDED |=> pc_out == $past(pc_out) + PC_STEP_THREE)
    else $error("extended pc step wrong");

  chk_idx8_range: assert property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_INDEXED_8 |=> ea_out.effective_address[15:9] == 7'h00)
    else $error("indexed offset address out of range");

  chk_bitbr_carry: assert property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_BIT_BRANCH
    |=> regs_out.carry == $past(operand_data[instr.opcode[3:1]]))
    else $error("tested bit not in carry");

  cov_soft_int: cover property (@(posedge sys_clk) disable iff (!rst_b)
    issue && instr.opcode == OP_SOFT_INTERRUPT && mode == MODE_INHERENT);
  cov_branch_taken: cover property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_RELATIVE && branch_cond);
  cov_bit_branch: cover property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_BIT_BRANCH);
  cov_bit_clear: cover property (@(posedge sys_clk) disable iff (!rst_b)
    is_bit_clear);

  chk_idx16_sum: assert property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_INDEXED_16
    |=> ea_out.effective_address == $past({instr.byte1, instr.byte2}) + $past({8'h00, regs_out.index}))
    else $error("sixteen-bit indexed address wrong");

  chk_rel_untaken: assert property (@(posedge sys_clk) disable iff (!rst_b)
    issue && mode == MODE_RELATIVE && !branch_cond
    |=> pc_out == $past(pc_out) + PC_STEP_TWO && ea_out.effective_address == pc_out)
    else $error("untaken branch address wrong");

endmodule

// >>> mem_model.sv
`timescale 1ns/10ps
module mem_model
  import ctrl_ea_pkg::*;
(
  // Fetch side
  input  wire logic [15:0] fetch_addr,
  output instr_bytes_t     fetch_bytes,
  // Page-zero data side
  input  wire logic [7:0]  data_addr,
  output logic [7:0]       data_byte
);
  logic [7:0] mem [0:65535];

  // Unwritten bytes differ from their neighbours, so stale reads show
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i * 7);
  end

  // Fetch wraps at the top of the space
  assign fetch_bytes = {mem[fetch_addr], mem[fetch_addr + 16'h0001],
                        mem[fetch_addr + 16'h0002]};
  // Bit operands sit in page zero
  assign data_byte = mem[{8'h00, data_addr}];
endmodule

// >>> ctrl_ea_gen_tb.sv
`timescale 1ns/10ps
module ctrl_ea_gen_tb;
  import ctrl_ea_pkg::*;
  typedef struct {
    ea_result_t ea;
    core_regs_t regs;
    logic [3:0] pulses;
    int         cycles;
    bit         full;
    bit         chk_ea;
    bit         chk_bit;
    time        t_take;
  } note_t;

  logic         sys_clk;
  logic         rst_b;
  logic         instr_valid;
  logic         branch_cond;
  addr_mode_t   mode;
  logic [15:0]  fetch_addr;
  logic [7:0]   data_addr;
  instr_bytes_t instr;
  logic [7:0]   operand_data;
  logic         instr_ready;
  logic         instr_done;
  logic         stop_req;
  logic         wait_req;
  logic         is_bit_set;
  logic         is_bit_clear;
  ea_result_t   ea_out;
  core_regs_t   regs_out;
  logic [15:0]  pc_out;
  note_t        notes[$];
  int           err_count = 0;
  int           total_checks = 0;
  logic [3:0]   seen;
  logic [15:0]  pc_m;
  core_regs_t   regs_m;
  logic [7:0]   ctrl_ops [10] = '{8'h97, 8'h9f, 8'h99, 8'h98, 8'h9a, 8'h9b, 8'h9c, 8'h9d,
                                  8'h8e, 8'h8f};
  addr_mode_t   modes [9] = '{MODE_IMMEDIATE, MODE_DIRECT, MODE_EXTENDED, MODE_INDEXED_0,
                              MODE_INDEXED_8, MODE_INDEXED_16, MODE_RELATIVE,
                              MODE_BIT_SETCLR, MODE_BIT_BRANCH};

  ctrl_ea_gen ctrl_ea_gen_i (.sys_clk(sys_clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr(instr), .mode(mode), .branch_cond(branch_cond), .operand_data(operand_data),
    .instr_ready(instr_ready), .ea_out(ea_out), .regs_out(regs_out), .pc_out(pc_out),
    .instr_done(instr_done), .stop_req(stop_req), .wait_req(wait_req),
    .is_bit_set(is_bit_set), .is_bit_clear(is_bit_clear));
  mem_model mem_model_i (.fetch_addr(fetch_addr), .fetch_bytes(instr),
    .data_addr(data_addr), .data_byte(operand_data));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic fail(input string msg);
    err_count++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_addr(input note_t n);
    total_checks++;
    if (pc_out !== n.ea.next_pc || ea_out.next_pc !== n.ea.next_pc) fail("program counter");
    if (n.chk_ea && ea_out.effective_address !== n.ea.effective_address) fail("address");
    if (n.chk_bit && ea_out.bit_number !== n.ea.bit_number) fail("bit number");
  endtask

  task automatic check_regs(input core_regs_t e);
    total_checks++;
    if (regs_out !== e) fail("core registers");
  endtask

  task automatic check_time(input note_t n);
    total_checks++;
    if (($time - n.t_take) / 20 != n.cycles) fail("cycle count");
    if (seen !== n.pulses) fail("side pulses");
  endtask

  // Holds the request, with fresh bytes, while the block is busy
  task automatic issue(input logic [7:0] op, input addr_mode_t m, input logic [7:0] b1,
                       input logic [7:0] b2, input logic [7:0] d, input logic c);
    note_t       n;
    logic [15:0] t;
    logic        bit_v;
    n = '{default: 0};
    // Keep the tested byte out of the instruction's own bytes
    if (m == MODE_BIT_BRANCH) while ({8'h00, b1} - pc_m < 16'h0003) b1++;
    n.cycles = 2;
    n.chk_ea = (m != MODE_INHERENT);
    n.chk_bit = (m == MODE_BIT_SETCLR || m == MODE_BIT_BRANCH);
    n.ea.bit_number = op[3:1];
    n.ea.next_pc = pc_m + 16'h0001;
    bit_v = d[op[3:1]];
    case (m)
      MODE_INHERENT: begin
        case (op)
          8'h97: regs_m.index = regs_m.acc;
          8'h9f: regs_m.acc = regs_m.index;
          8'h99: regs_m.carry = 1'b1;
          8'h98: regs_m.carry = 1'b0;
          8'h9b: regs_m.irq_mask = 1'b1;
          8'h9a: regs_m.irq_mask = 1'b0;
          8'h9c: regs_m.sp = 8'hff;
          8'h8e: n.pulses = 4'h8;
          8'h8f: n.pulses = 4'h4;
          8'h83: n.cycles = 10;
          8'h81: n.cycles = 6;
          8'h80: n.cycles = 9;
          default: ;
        endcase
      end
      MODE_IMMEDIATE: n.ea[34:3] = {pc_m + 16'h0001, pc_m + 16'h0002};
      MODE_DIRECT: n.ea[34:3] = {8'h00, b1, pc_m + 16'h0002};
      MODE_BIT_SETCLR: begin
        n.ea[34:3] = {8'h00, b1, pc_m + 16'h0002};
        n.pulses = op[0] ? 4'h1 : 4'h2;
      end
      MODE_EXTENDED: n.ea[34:3] = {b1, b2, pc_m + 16'h0003};
      MODE_INDEXED_0: n.ea[34:3] = {8'h00, regs_m.index, pc_m + 16'h0001};
      MODE_INDEXED_8: n.ea[34:3] = {16'(regs_m.index) + 16'(b1), pc_m + 16'h0002};
      MODE_INDEXED_16: n.ea[34:3] = {{b1, b2} + 16'(regs_m.index), pc_m + 16'h0003};
      MODE_RELATIVE: begin
        t = pc_m + 16'h0002 + (c ? {{8{b1[7]}}, b1} : 16'h0000);
        n.ea[34:3] = {t, t};
      end
      default: begin
        t = pc_m + 16'h0003 + ((bit_v ^ op[0]) ? {{8{b2[7]}}, b2} : 16'h0000);
        n.ea[34:3] = {8'h00, b1, t};
        regs_m.carry = bit_v;
      end
    endcase
    n.full = (n.cycles == 2);
    n.regs = regs_m;
    if (m == MODE_BIT_BRANCH) mem_model_i.mem[{8'h00, b1}] <= d;
    mem_model_i.mem[pc_m] <= op;
    mem_model_i.mem[pc_m + 16'h0001] <= b1;
    mem_model_i.mem[pc_m + 16'h0002] <= b2;
    fetch_addr <= pc_m;
    data_addr <= b1;
    mode <= m;
    branch_cond <= c;
    instr_valid <= 1'b1;
    pc_m = n.ea.next_pc;
    forever begin
      @(negedge sys_clk);
      if (instr_ready === 1'b1) break;
    end
    @(posedge sys_clk);
    n.t_take = $time;
    notes.push_back(n);
  endtask

  task automatic do_reset(input int cyc);
    instr_valid <= 1'b0;
    for (int k = 0; k < 40 && notes.size() > 0; k++) @(posedge sys_clk);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (cyc) @(posedge sys_clk);
    rst_b <= 1'b1;
    pc_m = 16'h0000;
    regs_m = '{acc: ACC_RESET, index: 8'h00, sp: 8'hff, carry: 1'b0, irq_mask: 1'b1};
    @(negedge sys_clk);
    check_regs(regs_m);
    total_checks++;
    if (pc_out !== 16'h0000 || instr_ready !== 1'b1) fail("reset state");
    @(posedge sys_clk);
  endtask

  // Results are matched in issue order as each completion appears
  always @(posedge sys_clk) begin
    note_t n;
    if (rst_b !== 1'b1) begin
      seen = 4'h0;
    end else begin
      seen = seen | {stop_req, wait_req, is_bit_set, is_bit_clear};
      if (instr_done === 1'b1) begin
        if (notes.size() == 0) begin
          fail("completion with nothing issued");
        end else begin
          n = notes.pop_front();
          check_time(n);
          if (n.full) check_addr(n);
          if (n.full) check_regs(n.regs);
          seen = 4'h0;
        end
      end
    end
  end

  initial begin
    logic [7:0]  op;
    logic [31:0] r;
    branch_cond = 1'b0;
    mode = MODE_INHERENT;
    fetch_addr = 16'h0000;
    data_addr = 8'h00;
    rst_b = 1'b0;
    void'($urandom(32'h60e6b10e));
    do_reset(20);
    foreach (ctrl_ops[i]) issue(ctrl_ops[i], MODE_INHERENT, 8'h00, 8'h00, 8'h00, 1'b0);
    for (int j = 0; j < 9; j++) begin
      for (int k = 0; k < 16; k++) begin
        r = $urandom;
        op = (j == 7) ? {4'h1, 4'(k)} : (j == 8) ? {4'h0, 4'(k)} : {3'b110, r[4:0]};
        if (k < 2) r[15:8] = k ? 8'h7f : 8'h80;
        issue(op, modes[j], r[15:8], r[23:16], r[31:24], r[5] | (k < 2));
      end
    end
    issue(8'h83, MODE_INHERENT, 8'h00, 8'h00, 8'h00, 1'b0);
    issue(8'h81, MODE_INHERENT, 8'h00, 8'h00, 8'h00, 1'b0);
    issue(8'h80, MODE_INHERENT, 8'h00, 8'h00, 8'h00, 1'b0);
    do_reset(3);
    final_report();
  end

  initial begin
    #200000;
    fail("watchdog expired");
    final_report();
  end
endmodule
